// File: core/address_breakpoint_unit.sv
/*
  Address breakpoint unit: compares CPU and DMA addresses with a
  programmed break address and raises break requests to the CPU.
  Assumes one 25 MHz clock, the CPU core and DMA engine on the same
  clock, and the test-voltage detect arriving from a pin.
*/
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
module address_breakpoint_unit (
  input  wire logic              clk,              // Bus clock
  input  wire logic              reset,            // Async reset
  input  wire logic              hsel,             // AHB select
  input  wire logic [31:0]       haddr,            // AHB address
  input  wire logic [1:0]        htrans,           // AHB transfer
  input  wire logic              hwrite,           // AHB write
  input  wire logic [2:0]        hsize,            // AHB size
  input  wire logic [31:0]       hwdata,           // AHB write data
  input  wire logic              hready,           // AHB ready in
  output logic [31:0]            hrdata,           // AHB read data
  output logic                   hreadyout,        // AHB ready out
  output logic                   hresp,            // AHB response
  input  wire brk_pkg::cpu_cycle_t cpu_cycle,      // CPU bus cycle
  input  wire brk_pkg::dma_cycle_t dma_cycle,      // DMA bus cycle
  input  wire logic              rti_executed,     // Return opcode done
  input  wire logic              wait_mode,        // CPU in wait
  input  wire logic              stop_mode,        // CPU in stop
  input  wire logic              test_voltage_pin, // High voltage seen
  output logic                   break_request,    // Break to CPU
  output logic                   insert_swi,       // Load swi opcode
  output logic [15:0]            break_vector,     // Vector address
  output logic                   dma_release,      // DMA give up bus
  output logic                   dma_keep_arbitrate, // Arbitrate on
  output logic                   timer_halt,       // Timer freeze
  output logic                   watchdog_hold,    // Watchdog off
  output logic                   flag_clear_allow, // Flag clear ok
  output logic                   wait_exit         // Leave wait mode
);

  // ========================================================
  // Registers
  logic [7:0]  break_address_high;
  logic [7:0]  break_address_low;
  logic        match_break_enable;
  logic        break_active_flag;
  logic        wait_exit_break_flag;
  logic        flag_clear_in_break_enable;
  logic        monitor_mode;
  brk_pkg::brk_state_t state;
  brk_pkg::brk_state_t next_state;
  logic [1:0]  tv_sync;

  // ========================================================
  // Bus slave
  logic        ph_valid;
  logic        ph_write;
  logic [15:0] ph_index;

  function automatic logic is_reg(input logic [15:0] idx,
                                  input logic [15:0] reg_idx);
    return idx == reg_idx;
  endfunction

  // Address phase kept for the write data phase
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_index <= 16'h0000;
    end else if (hready) begin
      ph_valid <= hsel && htrans[1];
      ph_write <= hwrite;
      ph_index <= haddr[17:2];
    end
  end

  logic wr_en;
  logic [7:0] wbyte;
  assign wr_en = ph_valid && ph_write;
  assign wbyte = hwdata[7:0];

  logic wr_bsc;
  logic wr_bah;
  logic wr_bal;
  logic wr_bws;
  logic wr_bfc;
  logic wr_mode;
  logic dma_bsc;
  assign wr_bsc  = wr_en && is_reg(ph_index,
                                   brk_pkg::idx_break_status_control);
  assign wr_bah  = wr_en && is_reg(ph_index,
                                   brk_pkg::idx_break_address_high);
  assign wr_bal  = wr_en && is_reg(ph_index,
                                   brk_pkg::idx_break_address_low);
  assign wr_bws  = wr_en && is_reg(ph_index,
                                   brk_pkg::idx_break_wait_status);
  assign wr_bfc  = wr_en && is_reg(ph_index,
                                   brk_pkg::idx_break_flag_control);
  assign wr_mode = wr_en && is_reg(ph_index,
                                   brk_pkg::idx_mode_control);
  // Address window of the status control register on the DMA path
  assign dma_bsc = dma_cycle.active && dma_cycle.write &&
                   dma_cycle.addr == brk_pkg::idx_break_status_control;

  // Zero wait states, always OKAY
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      hreadyout <= 1'b1;
    else
      hreadyout <= 1'b1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      hresp <= 1'b0;
    else
      hresp <= 1'b0;
  end

  // ========================================================
  // Comparator
  logic [15:0] break_address;
  logic        compare_on;
  logic        cpu_hit;
  logic        dma_hit;
  logic        soft_break;

  assign break_address = {break_address_high, break_address_low};
  assign compare_on = match_break_enable && !stop_mode;
  assign cpu_hit = compare_on && cpu_cycle.valid &&
                   cpu_cycle.addr == break_address;
  assign dma_hit = compare_on && dma_cycle.active &&
                   dma_cycle.addr == break_address;
  assign soft_break = (wr_bsc && wbyte[brk_pkg::bit_break_active_flag])
                   || (dma_bsc &&
                       dma_cycle.wdata[brk_pkg::bit_break_active_flag]);

  // ========================================================
  // Address bytes
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      break_address_high <= brk_pkg::rst_byte;
    else if (wr_bah)
      break_address_high <= wbyte;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      break_address_low <= brk_pkg::rst_byte;
    else if (wr_bal)
      break_address_low <= wbyte;
  end

  // ========================================================
  // Status and control
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      match_break_enable <= 1'b0;
    end else if (dma_bsc && wait_mode) begin
      match_break_enable <=
        dma_cycle.wdata[brk_pkg::bit_match_break_enable];
    end else if (wr_bsc) begin
      match_break_enable <= wbyte[brk_pkg::bit_match_break_enable];
    end
  end

  // Set wins over a software clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      break_active_flag <= 1'b0;
    end else if (cpu_hit || dma_hit || soft_break) begin
      break_active_flag <= 1'b1;
    end else if (wr_bsc || (dma_bsc && wait_mode)) begin
      break_active_flag <= 1'b0;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wait_exit_break_flag <= 1'b0;
    end else if (dma_bsc || (wait_mode && dma_hit) ||
                 (wait_mode && next_state == brk_pkg::st_break &&
                  state != brk_pkg::st_break)) begin
      wait_exit_break_flag <= 1'b1;
    end else if (wr_bws && !wbyte[brk_pkg::bit_wait_exit_break_flag]) begin
      wait_exit_break_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      flag_clear_in_break_enable <= 1'b0;
    else if (wr_bfc)
      flag_clear_in_break_enable <=
        wbyte[brk_pkg::bit_flag_clear_in_break_enable];
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      monitor_mode <= 1'b0;
    else if (wr_mode)
      monitor_mode <= wbyte[brk_pkg::bit_monitor_mode];
  end

  // ========================================================
  // Break sequencing
  // A match off the last cycle waits in st_pend
  always_comb begin
    next_state = state;
    case (state)
      brk_pkg::st_run: begin
        if (stop_mode)
          next_state = brk_pkg::st_run;
        else if (cpu_hit && cpu_cycle.last_cycle)
          next_state = brk_pkg::st_break;
        else if (cpu_hit || dma_hit || soft_break)
          next_state = brk_pkg::st_pend;
      end
      brk_pkg::st_pend: begin
        if (cpu_cycle.last_cycle || wait_mode)
          next_state = brk_pkg::st_break;
      end
      brk_pkg::st_break: begin
        if (rti_executed)
          next_state = brk_pkg::st_run;
      end
      default: next_state = brk_pkg::st_run;
    endcase
  end

  // Gray path: run, pend, break
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      state <= brk_pkg::st_run;
    else
      state <= next_state;
  end

  // ========================================================
  // Test voltage synchroniser, second stage only is read
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      tv_sync <= 2'b00;
    else
      tv_sync <= {tv_sync[0], test_voltage_pin};
  end

  // ========================================================
  // Outputs
  logic in_break_next;
  assign in_break_next = next_state == brk_pkg::st_break;

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      break_request <= 1'b0;
    else
      break_request <= next_state != brk_pkg::st_run;
  end

  // One-cycle pulse on entry into the break state
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      insert_swi <= 1'b0;
    else
      insert_swi <= in_break_next &&
                    state != brk_pkg::st_break;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      break_vector <= brk_pkg::vec_user;
    else
      break_vector <= monitor_mode ? brk_pkg::vec_monitor
                                   : brk_pkg::vec_user;
  end

  // ========================================================
  // DMA side
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      dma_release <= 1'b0;
    else
      dma_release <= next_state != brk_pkg::st_run;
  end

  // Channel arbitration never stops for a break
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      dma_keep_arbitrate <= 1'b1;
    else
      dma_keep_arbitrate <= 1'b1;
  end

  // ========================================================
  // Freeze and flag protection
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      timer_halt <= 1'b0;
    else
      timer_halt <= in_break_next;
  end

  // Only the second synchroniser stage is read
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      watchdog_hold <= 1'b0;
    else
      watchdog_hold <= in_break_next && tv_sync[1];
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      flag_clear_allow <= 1'b1;
    else
      flag_clear_allow <= !in_break_next ||
                          flag_clear_in_break_enable;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      wait_exit <= 1'b0;
    else
      wait_exit <= wait_mode && in_break_next;
  end

  // ========================================================
  // Read data
  // Reads have no side effects; bytes sit in the low lane
  // Decoded in the address phase: a read right behind a write
  // to the same register returns the byte before that write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= 32'h0000_0000;
      case (haddr[17:2])
        brk_pkg::idx_break_status_control:
          hrdata[7:0] <= {match_break_enable, break_active_flag, 6'h00};
        brk_pkg::idx_break_address_high:
          hrdata[7:0] <= break_address_high;
        brk_pkg::idx_break_address_low:
          hrdata[7:0] <= break_address_low;
        brk_pkg::idx_break_wait_status:
          hrdata[7:0] <= {6'h00, wait_exit_break_flag, 1'b0};
        brk_pkg::idx_break_flag_control:
          hrdata[7:0] <= {flag_clear_in_break_enable, 7'h00};
        brk_pkg::idx_mode_control:
          hrdata[7:0] <= {7'h00, monitor_mode};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // address_breakpoint_unit

// File: core/brk_pkg.sv
/*
  Package for the address breakpoint unit: register offsets, field
  positions, reset values and the packed carriers used by the core.
  Assumes an AHB-Lite slave with 32-bit data, one register per word.
*/
package brk_pkg;

  // ==========================================================
  // Register indices (printed offsets are not word aligned)
  localparam logic [15:0] idx_break_wait_status    = 16'hfe00;
  localparam logic [15:0] idx_break_flag_control   = 16'hfe03;
  localparam logic [15:0] idx_break_address_high   = 16'hfe0c;
  localparam logic [15:0] idx_break_address_low    = 16'hfe0d;
  localparam logic [15:0] idx_break_status_control = 16'hfe0e;
  localparam logic [15:0] idx_mode_control         = 16'hfe10;

  // ==========================================================
  // Field positions
  localparam int bit_match_break_enable        = 7;
  localparam int bit_break_active_flag         = 6;
  localparam int bit_wait_exit_break_flag      = 1;
  localparam int bit_flag_clear_in_break_enable = 7;
  localparam int bit_monitor_mode              = 0;

  // ==========================================================
  // Reset values
  localparam logic [7:0] rst_byte = 8'h00;

  // ==========================================================
  // Break vectors
  localparam logic [15:0] vec_user    = 16'hfffc;
  localparam logic [15:0] vec_monitor = 16'hfefc;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic        valid;      // Address cycle valid
    logic [15:0] addr;       // Address on the internal bus
    logic        last_cycle; // Final cycle of CPU instruction
  } cpu_cycle_t;

  typedef struct packed {
    logic        active;     // DMA owns the bus this cycle
    logic [15:0] addr;       // DMA generated address
    logic        write;      // DMA write cycle
    logic [7:0]  wdata;      // DMA write data
  } dma_cycle_t;

  typedef enum logic [1:0] {
    st_run   = 2'b00,
    st_pend  = 2'b01,
    st_break = 2'b11
  } brk_state_t;

endpackage

// File: verification/address_breakpoint_unit_assertions.sv
/* Port checker for the breakpoint unit.
   Assumes one clock, bound onto every unit instance. */
`timescale 1ns/1ps
module abu_checker (
  input wire logic        clk,                // Bus clock
  input wire logic        reset,              // Async reset
  input wire logic [31:0] hrdata,             // Read data
  input wire logic        hreadyout,          // Ready out
  input wire logic        hresp,              // Response
  input wire logic        rti_executed,       // Return done
  input wire logic        stop_mode,          // Stop level
  input wire logic        test_voltage_pin,   // Test voltage
  input wire logic        break_request,      // Break to CPU
  input wire logic        insert_swi,         // Opcode load
  input wire logic [15:0] break_vector,       // Vector
  input wire logic        dma_release,        // DMA release
  input wire logic        dma_keep_arbitrate, // Arbitrate on
  input wire logic        timer_halt,         // Timer freeze
  input wire logic        watchdog_hold,      // Watchdog off
  input wire logic        flag_clear_allow,   // Clear allowed
  input wire logic        wait_exit           // Wait exit
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_OKAY: assert property (
    hreadyout && !hresp) else $error("bus answer not OKAY");
  AST_UPPER: assert property (
    hrdata[31:8] == 24'h0) else $error("upper read bits set");
  AST_SWI: assert property (
    insert_swi |-> break_request && timer_halt ##1 !insert_swi)
    else $error("opcode load pulse wrong");
  AST_REL: assert property (
    dma_release == break_request) else $error("release mismatch");
  AST_ARB: assert property (
    dma_keep_arbitrate) else $error("arbitration stopped");
  AST_RTI: assert property (
    rti_executed |=> !break_request && !timer_halt)
    else $error("return did not end break");
  AST_WDOG_OFF: assert property (
    !test_voltage_pin [*4] |-> !watchdog_hold)
    else $error("watchdog held without voltage");
  AST_WDOG_BRK: assert property (
    watchdog_hold |-> timer_halt) else $error("watchdog held off break");
  AST_VEC: assert property (
    break_vector inside {16'hfffc, 16'hfefc}) else $error("bad vector");
  AST_FCLR: assert property (
    !flag_clear_allow |-> timer_halt) else $error("clear blocked off break");
  AST_WEXIT: assert property (
    wait_exit |-> timer_halt) else $error("wait exit off break");
  AST_STOP: assert property (
    stop_mode && !break_request |=> !break_request)
    else $error("break raised in stop");
endmodule // abu_checker
bind address_breakpoint_unit abu_checker CHK (.clk, .reset, .hrdata,
  .hreadyout, .hresp, .rti_executed, .stop_mode, .test_voltage_pin,
  .break_request, .insert_swi, .break_vector, .dma_release,
  .dma_keep_arbitrate, .timer_halt, .watchdog_hold, .flag_clear_allow,
  .wait_exit);

// File: verification/cpu_dma_model.sv
/* CPU core and DMA engine seen from the breakpoint unit.
   Assumes the bench calls its tasks; a released bus shows inverses. */
`timescale 1ns/1ps
module cpu_dma_model (
  input  wire logic           clk,          // Bus clock
  input  wire logic           dma_release,  // Break holds DMA off
  output brk_pkg::cpu_cycle_t cpu_cycle,    // CPU address cycle
  output brk_pkg::dma_cycle_t dma_cycle,    // DMA address cycle
  output logic                rti_executed  // Return opcode done
);
  initial begin
    cpu_cycle = '0;
    dma_cycle = '0;
    rti_executed = 1'b0;
  end
  task automatic fetch(input logic [15:0] a, input logic l);
    @(posedge clk);
    cpu_cycle <= '{1'b1, a, l};
    @(posedge clk);
    cpu_cycle <= '{1'b0, ~a, 1'b0};
  endtask
  task automatic dma(input logic [15:0] a, input logic w,
                     input logic [7:0] d);
    @(posedge clk);
    dma_cycle <= '{!dma_release, a, w, d};
    @(posedge clk);
    dma_cycle <= '{1'b0, ~a, 1'b0, ~d};
  endtask
  task automatic return_from_interrupt_opcode;
    @(posedge clk);
    rti_executed <= 1'b1;
    @(posedge clk);
    rti_executed <= 1'b0;
  endtask
endmodule // cpu_dma_model

// File: verification/address_breakpoint_unit_tb.sv
/* Self-checking bench for the breakpoint unit over AHB-Lite.
   Assumes the CPU and DMA model and the bound checker. */
`timescale 1ns/1ps
module address_breakpoint_unit_tb;
  localparam logic [15:0] ws = brk_pkg::idx_break_wait_status;
  localparam logic [15:0] fc = brk_pkg::idx_break_flag_control;
  localparam logic [15:0] ah = brk_pkg::idx_break_address_high;
  localparam logic [15:0] al = brk_pkg::idx_break_address_low;
  localparam logic [15:0] sc = brk_pkg::idx_break_status_control;
  localparam logic [15:0] mc = brk_pkg::idx_mode_control;
  logic clk = 0, reset = 1, hsel = 0, hwrite = 0;
  logic wait_mode = 0, stop_mode = 0, test_voltage_pin = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
  logic [1:0]  htrans = '0;
  logic [2:0]  hsize = 3'b010;
  logic [15:0] break_vector;
  logic hreadyout, hresp, break_request, insert_swi, dma_release;
  logic dma_keep_arbitrate, timer_halt, watchdog_hold;
  logic flag_clear_allow, wait_exit, rti_executed;
  brk_pkg::cpu_cycle_t cpu_cycle;
  brk_pkg::dma_cycle_t dma_cycle;
  int mismatches = 0, samples_checked = 0;
  always #20 clk = ~clk;
  address_breakpoint_unit DUT (.clk, .reset, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp,
    .cpu_cycle, .dma_cycle, .rti_executed, .wait_mode, .stop_mode,
    .test_voltage_pin, .break_request, .insert_swi, .break_vector,
    .dma_release, .dma_keep_arbitrate, .timer_halt, .watchdog_hold,
    .flag_clear_allow, .wait_exit);
  cpu_dma_model P (.clk, .dma_release, .cpu_cycle, .dma_cycle,
    .rti_executed);
  task automatic chk(input string n, input logic [31:0] e, s);
    samples_checked++;
    if (s !== e) begin
      $display("FAIL %s expected %h seen %h", n, e, s);
      mismatches++;
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] i,
                     input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {14'h0, i, 2'b00};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'ha5a5a5, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    bus(1'b1, i, d);
  endtask
  task automatic rd(input logic [15:0] i, input logic [7:0] e, string n);
    bus(1'b0, i, 8'h00);
    chk(n, {24'h0, e}, q);
  endtask
  task automatic look;
    @(negedge clk);
  endtask
  // Completes a break, clears the active flag, returns
  task automatic leave;
    P.fetch(16'h0000, 1'b1);
    wr(sc, 8'h80);
    P.return_from_interrupt_opcode();
    look;
    chk("break_request", 0, break_request);
  endtask
  task print_verdict;
    if (mismatches == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    print_verdict;
  end
  initial begin
    repeat (4) @(posedge clk);
    reset <= 0;
    rd(sc, 8'h00, "status_control");
    rd(ws, 8'h00, "wait_status");
    rd(ah, 8'h00, "address_high");
    rd(al, 8'h00, "address_low");
    rd(16'h0100, 8'h00, "unmapped");
    wr(ah, 8'h12);
    wr(al, 8'h34);
    rd(ah, 8'h12, "address_high");
    rd(al, 8'h34, "address_low");
    P.fetch(16'h1234, 1'b1);
    look;
    chk("break_request", 0, break_request);
    wr(sc, 8'h80);
    P.fetch(16'h1234, 1'b1);
    look;
    chk("insert_swi", 1, insert_swi);
    chk("timer_halt", 1, timer_halt);
    chk("dma_release", 1, dma_release);
    chk("flag_clear_allow", 0, flag_clear_allow);
    rd(sc, 8'hc0, "status_control");
    wr(fc, 8'h80);
    look;
    look;
    chk("flag_clear_allow", 1, flag_clear_allow);
    wr(fc, 8'h00);
    leave;
    @(posedge clk) wait_mode <= 1'b1;
    P.dma(16'h1234, 1'b0, 8'h00);
    P.fetch(16'h0000, 1'b1);
    look;
    chk("wait_exit", 1, wait_exit);
    rd(ws, 8'h02, "wait_status");
    wr(ws, 8'h00);
    rd(ws, 8'h00, "wait_status");
    leave;
    P.dma(sc, 1'b1, 8'h00);
    rd(ws, 8'h02, "wait_status");
    rd(sc, 8'h00, "status_control");
    wr(ws, 8'h00);
    @(posedge clk) wait_mode <= 1'b0;
    wr(sc, 8'h40);
    look;
    chk("break_request", 1, break_request);
    leave;
    @(posedge clk) stop_mode <= 1'b1;
    P.fetch(16'h1234, 1'b1);
    look;
    chk("break_request", 0, break_request);
    rd(al, 8'h34, "address_low");
    rd(sc, 8'h80, "status_control");
    @(posedge clk) stop_mode <= 1'b0;
    @(posedge clk) test_voltage_pin <= 1'b1;
    wr(mc, 8'h01);
    P.fetch(16'h1234, 1'b0);
    look;
    chk("break_request", 1, break_request);
    P.fetch(16'h2000, 1'b1);
    look;
    chk("insert_swi", 1, insert_swi);
    chk("break_vector", 32'h0000fefc, break_vector);
    chk("watchdog_hold", 1, watchdog_hold);
    leave;
    print_verdict;
  end
endmodule // address_breakpoint_unit_tb
